// ==== design/oag_pkg.sv ====
package oag_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0]  OAG_RPS_OFS    = 8'he1;   // Page select for direct-page data
  localparam logic [7:0]  OAG_XPTR_OFS   = 8'hdc;   // First index register
  localparam logic [7:0]  OAG_YPTR_OFS   = 8'hdd;   // Second index register
  localparam logic [7:0]  OAG_STAT_OFS   = 8'hde;   // Read-only block status

  // Status field positions
  localparam int          OAG_STAT_BANK  = 0;       // Bank flag as held now
  localparam int          OAG_STAT_BUSY  = 1;       // Indirect fetch in progress

  // Values after reset
  localparam logic [7:0]  OAG_RPS_RST    = 8'h00;   // Page select after reset
  localparam logic [7:0]  OAG_PTR_RST    = 8'h00;   // Index registers after reset
  localparam logic        OAG_BANK_RST   = 1'b0;    // Bank flag after reset

  // Arithmetic constants
  localparam logic [7:0]  OAG_PAGE_ZERO  = 8'h00;   // Page used while bank flag is clear
  localparam logic [7:0]  OAG_INC8       = 8'h01;   // Byte step
  localparam logic [15:0] OAG_INC16      = 16'h0001; // Word step for absolute pointers
  localparam logic [7:0]  OAG_ZERO8      = 8'h00;   // Zero byte

  // Addressing variants, grouped into the six families
  typedef enum logic [3:0] {
    OAG_M_REG     = 4'h0,   // Register
    OAG_M_IMM     = 4'h1,   // Immediate
    OAG_M_PG      = 4'h2,   // Direct page
    OAG_M_ABS     = 4'h3,   // Absolute, also read-modify-write
    OAG_M_XIND    = 4'h4,   // Indexed: {X}
    OAG_M_PGX     = 4'h5,   // Indexed: page+X
    OAG_M_XINC    = 4'h6,   // Indexed: {X}+
    OAG_M_PGY     = 4'h7,   // Indexed: page+Y
    OAG_M_ABSY    = 4'h8,   // Indexed: !abs+Y
    OAG_M_IND_PG  = 4'h9,   // Indirect: [page] jump or call
    OAG_M_IND_PGY = 4'ha,   // Indirect: [page]+Y
    OAG_M_IND_PGX = 4'hb,   // Indirect: [page+X]
    OAG_M_IND_ABS = 4'hc    // Indirect: [!abs] jump
  } oag_mode_t;

  // Core register named by register addressing
  typedef enum logic [2:0] {
    OAG_R_ACC   = 3'h0,
    OAG_R_XPTR  = 3'h1,
    OAG_R_YPTR  = 3'h2,
    OAG_R_CARRY = 3'h3,
    OAG_R_PSW   = 3'h4
  } oag_rsel_t;

  // What a result carries
  typedef enum logic [1:0] {
    OAG_K_REG  = 2'h0,   // Register operand, no memory access
    OAG_K_IMM  = 2'h1,   // Operand value in imm
    OAG_K_DATA = 2'h2,   // Data address in addr
    OAG_K_JUMP = 2'h3    // Jump target in addr
  } oag_kind_t;

  // Indirect fetch sequencer, one-hot
  typedef enum logic [4:0] {
    OAG_S_IDLE = 5'b00001,   // Ready for a request
    OAG_S_LO   = 5'b00010,   // Low pointer byte strobe out
    OAG_S_LOD  = 5'b00100,   // Low byte on read data
    OAG_S_HI   = 5'b01000,   // High pointer byte strobe out
    OAG_S_HID  = 5'b10000    // High byte on read data
  } oag_state_t;

  // Decode request from the core
  typedef struct packed {
    logic      valid;
    oag_mode_t mode;
    oag_rsel_t rsel;
    logic [7:0] op_lo;   // Second instruction byte
    logic [7:0] op_hi;   // Third instruction byte
  } oag_req_t;

  // Effective operand result
  typedef struct packed {
    logic       valid;
    oag_kind_t  kind;
    oag_rsel_t  rsel;
    logic [7:0] imm;
    logic [15:0] addr;
  } oag_res_t;

endpackage

// ==== design/oag_index_regs.sv ====
module oag_index_regs (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_x,     // Software write of first index
  input  wire logic       wr_y,     // Software write of second index
  input  wire logic [7:0] wdata,    // Write value
  input  wire logic       inc_x,    // Post-increment after {X}+ access
  output logic      [7:0] x_q,      // First index register
  output logic      [7:0] y_q       // Second index register
);

  logic [7:0] x_d;   // Next first index
  logic [7:0] y_d;   // Next second index

  // Next values; a software write outranks the increment in the same cycle
  always_comb begin
    x_d = x_q;
    y_d = y_q;
    if (wr_x) begin
      x_d = wdata;
    end else if (inc_x) begin
      x_d = x_q + oag_pkg::OAG_INC8;
    end
    if (wr_y) begin
      y_d = wdata;
    end
  end

  // Storage; the 8-bit sum wraps to zero and touches no flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_q <= oag_pkg::OAG_PTR_RST;
      y_q <= oag_pkg::OAG_PTR_RST;
    end else begin
      x_q <= x_d;
      y_q <= y_d;
    end
  end

endmodule

// ==== design/oag_top.sv ====
module oag_top (
  input  wire logic             clk,
  input  wire logic             rstn,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // Bank flag instructions from the core
  input  wire logic             set_bank_bit,
  input  wire logic             clear_bank_bit,
  // Decode request and result
  input  wire oag_pkg::oag_req_t req,
  output oag_pkg::oag_res_t     res,
  output logic                  busy,
  // Data memory read port for pointer fetches
  output logic                  mem_rd,
  output logic      [15:0]      mem_addr,
  input  wire logic [7:0]       mem_rdata
);

  // Reset release synchroniser
  logic rst_s1_q;    // First stage, read only by the second
  logic rst_n_q;     // Released reset used everywhere else

  // Reset asserts at once and releases two edges later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Block state
  logic [7:0]          rps_q, rps_d;           // Page select register
  logic                bank_q, bank_d;         // Bank flag
  logic [7:0]          rdata_q, rdata_d;       // Register read data
  oag_pkg::oag_state_t st_q, st_d;             // Fetch sequencer
  oag_pkg::oag_res_t   res_q, res_d;           // Result register
  logic                mem_rd_q, mem_rd_d;     // Memory read strobe
  logic [15:0]         mem_addr_q, mem_addr_d; // Memory read address
  logic [15:0]         hi_addr_q, hi_addr_d;   // Address of pointer high byte
  logic [7:0]          lo_byte_q, lo_byte_d;   // Captured pointer low byte
  logic                add_y_q, add_y_d;       // Post-index with second index
  oag_pkg::oag_kind_t  kind_q, kind_d;         // Kind of the pending result
  logic                busy_q, busy_d;         // Fetch in progress

  // Index registers
  logic [7:0] x_q;      // First index
  logic [7:0] y_q;      // Second index
  logic       inc_x;    // Post-increment pulse
  logic       wr_x;     // Software write of first index
  logic       wr_y;     // Software write of second index

  // Decode helpers
  logic [7:0]  page;       // Upper byte of any direct-page address
  logic [15:0] abs_addr;   // Two-byte absolute address from the second and third bytes
  logic [7:0]  sum_x;      // Operand plus first index
  logic [7:0]  sum_y;      // Operand plus second index
  logic [15:0] ptr_word;   // Fetched pointer as a word

  assign wr_x = reg_wr && (reg_addr == oag_pkg::OAG_XPTR_OFS);
  assign wr_y = reg_wr && (reg_addr == oag_pkg::OAG_YPTR_OFS);

  // Page byte; page zero whenever the bank flag is clear
  assign page     = bank_q ? rps_q : oag_pkg::OAG_PAGE_ZERO;
  // Low byte from the second byte, high from the third
  assign abs_addr = {req.op_hi, req.op_lo};
  // Byte-wide sums stay inside the selected page
  assign sum_x    = req.op_lo + x_q;
  assign sum_y    = req.op_lo + y_q;
  assign ptr_word = {mem_rdata, lo_byte_q};

  // Index register storage
  oag_index_regs u_index (
    .clk   (clk),
    .rst_n (rst_n_q),
    .wr_x  (wr_x),
    .wr_y  (wr_y),
    .wdata (reg_wdata),
    .inc_x (inc_x),
    .x_q   (x_q),
    .y_q   (y_q)
  );

  // Page select register and bank flag
  always_comb begin
    rps_d  = rps_q;
    bank_d = bank_q;
    if (reg_wr && (reg_addr == oag_pkg::OAG_RPS_OFS)) begin
      rps_d = reg_wdata;
    end
    // A new page takes effect only once the flag is set
    if (set_bank_bit) begin
      bank_d = 1'b1;
    end else if (clear_bank_bit) begin
      bank_d = 1'b0;
    end
  end

  // Register read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = oag_pkg::OAG_ZERO8;
    if (reg_rd) begin
      unique case (reg_addr)
        oag_pkg::OAG_RPS_OFS:  rdata_d = rps_q;
        oag_pkg::OAG_XPTR_OFS: rdata_d = x_q;
        oag_pkg::OAG_YPTR_OFS: rdata_d = y_q;
        oag_pkg::OAG_STAT_OFS: begin
          rdata_d[oag_pkg::OAG_STAT_BANK] = bank_q;
          rdata_d[oag_pkg::OAG_STAT_BUSY] = busy_q;
        end
        default:               rdata_d = oag_pkg::OAG_ZERO8;
      endcase
    end
  end

  // Register state
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rps_q   <= oag_pkg::OAG_RPS_RST;
      bank_q  <= oag_pkg::OAG_BANK_RST;
      rdata_q <= oag_pkg::OAG_ZERO8;
    end else begin
      rps_q   <= rps_d;
      bank_q  <= bank_d;
      rdata_q <= rdata_d;
    end
  end

  // Decode and pointer fetch; requests during a fetch are dropped
  always_comb begin
    st_d       = st_q;
    res_d      = res_q;
    res_d.valid = 1'b0;
    mem_rd_d   = 1'b0;
    mem_addr_d = mem_addr_q;
    hi_addr_d  = hi_addr_q;
    lo_byte_d  = lo_byte_q;
    add_y_d    = add_y_q;
    kind_d     = kind_q;
    busy_d     = busy_q;
    inc_x      = 1'b0;
    unique case (st_q)
      oag_pkg::OAG_S_IDLE: begin
        if (req.valid) begin
          res_d.rsel = req.rsel;
          res_d.imm  = oag_pkg::OAG_ZERO8;
          res_d.addr = 16'h0000;
          res_d.kind = oag_pkg::OAG_K_DATA;
          unique case (req.mode)
            oag_pkg::OAG_M_REG: begin
              // Core register only, no strobe raised
              res_d.valid = 1'b1;
              res_d.kind  = oag_pkg::OAG_K_REG;
            end
            oag_pkg::OAG_M_IMM: begin
              // Byte is the value, never an address
              res_d.valid = 1'b1;
              res_d.kind  = oag_pkg::OAG_K_IMM;
              res_d.imm   = req.op_lo;
            end
            oag_pkg::OAG_M_PG: begin
              res_d.valid = 1'b1;
              res_d.addr  = {page, req.op_lo};
            end
            oag_pkg::OAG_M_ABS: begin
              // Full word for every absolute op, modify ops included
              res_d.valid = 1'b1;
              res_d.addr  = abs_addr;
            end
            oag_pkg::OAG_M_XIND: begin
              res_d.valid = 1'b1;
              res_d.addr  = {page, x_q};
            end
            oag_pkg::OAG_M_PGX: begin
              res_d.valid = 1'b1;
              res_d.addr  = {page, sum_x};
            end
            oag_pkg::OAG_M_XINC: begin
              // Address uses the old index; the step lands next edge
              res_d.valid = 1'b1;
              res_d.addr  = {page, x_q};
              inc_x       = 1'b1;
            end
            oag_pkg::OAG_M_PGY: begin
              res_d.valid = 1'b1;
              res_d.addr  = {page, sum_y};
            end
            oag_pkg::OAG_M_ABSY: begin
              // Word-wide sum may cross pages
              res_d.valid = 1'b1;
              res_d.addr  = abs_addr + {oag_pkg::OAG_ZERO8, y_q};
            end
            oag_pkg::OAG_M_IND_PG: begin
              mem_rd_d   = 1'b1;
              mem_addr_d = {page, req.op_lo};
              hi_addr_d  = {page, req.op_lo + oag_pkg::OAG_INC8};
              kind_d     = oag_pkg::OAG_K_JUMP;
              add_y_d    = 1'b0;
              busy_d     = 1'b1;
              st_d       = oag_pkg::OAG_S_LO;
            end
            oag_pkg::OAG_M_IND_PGY: begin
              mem_rd_d   = 1'b1;
              mem_addr_d = {page, req.op_lo};
              hi_addr_d  = {page, req.op_lo + oag_pkg::OAG_INC8};
              kind_d     = oag_pkg::OAG_K_DATA;
              add_y_d    = 1'b1;
              busy_d     = 1'b1;
              st_d       = oag_pkg::OAG_S_LO;
            end
            oag_pkg::OAG_M_IND_PGX: begin
              mem_rd_d   = 1'b1;
              mem_addr_d = {page, sum_x};
              hi_addr_d  = {page, sum_x + oag_pkg::OAG_INC8};
              kind_d     = oag_pkg::OAG_K_DATA;
              add_y_d    = 1'b0;
              busy_d     = 1'b1;
              st_d       = oag_pkg::OAG_S_LO;
            end
            oag_pkg::OAG_M_IND_ABS: begin
              // Pair may straddle a page, so the step is word-wide
              mem_rd_d   = 1'b1;
              mem_addr_d = abs_addr;
              hi_addr_d  = abs_addr + oag_pkg::OAG_INC16;
              kind_d     = oag_pkg::OAG_K_JUMP;
              add_y_d    = 1'b0;
              busy_d     = 1'b1;
              st_d       = oag_pkg::OAG_S_LO;
            end
            default: begin
              // Unused mode codes give nothing
              res_d.valid = 1'b0;
            end
          endcase
        end
      end
      oag_pkg::OAG_S_LO: begin
        // Memory sees the low strobe this cycle
        st_d = oag_pkg::OAG_S_LOD;
      end
      oag_pkg::OAG_S_LOD: begin
        // Low byte first, then the high byte
        lo_byte_d  = mem_rdata;
        mem_rd_d   = 1'b1;
        mem_addr_d = hi_addr_q;
        st_d       = oag_pkg::OAG_S_HI;
      end
      oag_pkg::OAG_S_HI: begin
        st_d = oag_pkg::OAG_S_HID;
      end
      oag_pkg::OAG_S_HID: begin
        // Pointer complete; post-index if asked
        res_d.valid = 1'b1;
        res_d.kind  = kind_q;
        res_d.imm   = oag_pkg::OAG_ZERO8;
        res_d.addr  = add_y_q ? (ptr_word + {oag_pkg::OAG_ZERO8, y_q}) : ptr_word;
        busy_d      = 1'b0;
        st_d        = oag_pkg::OAG_S_IDLE;
      end
      default: begin
        // Illegal one-hot code recovers to idle
        busy_d = 1'b0;
        st_d   = oag_pkg::OAG_S_IDLE;
      end
    endcase
  end

  // Sequencer and output registers
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q       <= oag_pkg::OAG_S_IDLE;
      res_q      <= '0;
      mem_rd_q   <= 1'b0;
      mem_addr_q <= 16'h0000;
      hi_addr_q  <= 16'h0000;
      lo_byte_q  <= oag_pkg::OAG_ZERO8;
      add_y_q    <= 1'b0;
      kind_q     <= oag_pkg::OAG_K_DATA;
      busy_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      res_q      <= res_d;
      mem_rd_q   <= mem_rd_d;
      mem_addr_q <= mem_addr_d;
      hi_addr_q  <= hi_addr_d;
      lo_byte_q  <= lo_byte_d;
      add_y_q    <= add_y_d;
      kind_q     <= kind_d;
      busy_q     <= busy_d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = rdata_q;
  assign res       = res_q;
  assign busy      = busy_q;
  assign mem_rd    = mem_rd_q;
  assign mem_addr  = mem_addr_q;

endmodule

// ==== dv/oag_checker.sv ====
module oag_checker (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              set_bank_bit,
  input wire logic              clear_bank_bit,
  input wire oag_pkg::oag_req_t req,
  input wire oag_pkg::oag_res_t res,
  input wire logic              busy,
  input wire logic              mem_rd,
  input wire logic [15:0]       mem_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  // One clock domain, checks idle while reset is low
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Request taken this cycle; requests during busy are dropped
  logic take;
  assign take = req.valid && !busy;

  // Read data must not linger past its one cycle
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data seen without a read strobe");
  reg_mode_a: assert property (take && req.mode == oag_pkg::OAG_M_REG |=>
    res.valid && res.kind == oag_pkg::OAG_K_REG && res.rsel == $past(req.rsel))
    else $error("register mode result wrong");
  imm_value_a: assert property (take && req.mode == oag_pkg::OAG_M_IMM |=>
    res.valid && res.kind == oag_pkg::OAG_K_IMM && res.imm == $past(req.op_lo))
    else $error("immediate result wrong");
  page_low_a: assert property (take && req.mode == oag_pkg::OAG_M_PG |=>
    res.valid && res.kind == oag_pkg::OAG_K_DATA && res.addr[7:0] == $past(req.op_lo))
    else $error("direct page low byte wrong");
  abs_addr_a: assert property (take && req.mode == oag_pkg::OAG_M_ABS |=>
    res.valid && res.addr == {$past(req.op_hi), $past(req.op_lo)})
    else $error("absolute address wrong");
  // Pointer pair: low then high, high at next byte inside the page
  ind_pair_a: assert property (take && req.mode == oag_pkg::OAG_M_IND_PG |=>
    busy && mem_rd ##2 mem_rd && mem_addr[15:8] == $past(mem_addr[15:8], 2)
    && mem_addr[7:0] == $past(mem_addr[7:0], 2) + 8'h01
    ##2 res.valid && !busy && res.kind == oag_pkg::OAG_K_JUMP)
    else $error("page pointer fetch sequence wrong");
  abs_ptr_a: assert property (take && req.mode == oag_pkg::OAG_M_IND_ABS |=>
    mem_addr == {$past(req.op_hi), $past(req.op_lo)}
    ##2 mem_addr == $past(mem_addr, 2) + 16'h0001)
    else $error("absolute pointer fetch wrong");
  busy_quiet_a: assert property (busy |-> !res.valid)
    else $error("result during pointer fetch");
  mem_pulse_a: assert property (mem_rd |=> !mem_rd)
    else $error("fetch strobe longer than one cycle");
  // Cleared flag must force page zero whatever the page register holds
  page_zero_a: assert property ((clear_bank_bit && !set_bank_bit) ##1 !set_bank_bit
    ##1 (take && req.mode == oag_pkg::OAG_M_PG && !set_bank_bit) |=> res.addr[15:8] == 8'h00)
    else $error("page not zero after bank clear");

  // Main scenarios reached
  cover property (take && req.mode == oag_pkg::OAG_M_IND_PGY);
  cover property (take && req.mode == oag_pkg::OAG_M_XINC);
  cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

bind oag_top oag_checker i_oag_checker (
  .clk(clk), .rstn(rstn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .set_bank_bit(set_bank_bit), .clear_bank_bit(clear_bank_bit), .req(req), .res(res),
  .busy(busy), .mem_rd(mem_rd), .mem_addr(mem_addr)
);

// ==== dv/oag_top_tb.sv ====
module oag_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk;             // Core clock, 8 ns
  logic              rstn;            // Reset, active low
  logic [7:0]        reg_addr;        // Register port
  logic [7:0]        reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_rdata;
  logic              set_bank_bit;    // Bank flag pulses
  logic              clear_bank_bit;
  oag_pkg::oag_req_t req;             // Decode request
  oag_pkg::oag_res_t res;             // Decode result
  logic              busy;
  logic              mem_rd;          // Pointer fetch port
  logic [15:0]       mem_addr;
  logic [7:0]        mem_rdata;
  int                mismatches;
  int                total_checks;
  int                cyc;             // Cycles since start
  logic [7:0]        d8;              // Last read value
  oag_pkg::oag_res_t r;               // Last result

  oag_top i_oag_top (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .set_bank_bit(set_bank_bit),
    .clear_bank_bit(clear_bank_bit), .req(req), .res(res), .busy(busy),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata)
  );

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Memory bytes are a fixed function of address, so pointers are predictable
  function automatic logic [7:0] mbyte(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5a;
  endfunction

  // Data valid only in the cycle after a strobe; toggling junk otherwise
  always @(posedge clk) begin
    if (mem_rd === 1'b1) begin
      mem_rdata <= mbyte(mem_addr);
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end

  // Hang guard: the run needs about 113 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches = mismatches + 1;
      results();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read, data taken in the following cycle only
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic bank(input logic s, input logic c);
    @(posedge clk);
    set_bank_bit   <= s;
    clear_bank_bit <= c;
    @(posedge clk);
    set_bank_bit   <= 1'b0;
    clear_bank_bit <= 1'b0;
  endtask

  // One request, then bounded wait for its result
  task automatic dec(input oag_pkg::oag_mode_t m, input logic [2:0] s,
                     input logic [7:0] lo, input logic [7:0] hi);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, m, oag_pkg::oag_rsel_t'(s), lo, hi};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    while (res.valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 8) chk(16'h0000, 16'h0001);
    r = res;
  endtask

  // Request plus kind and address compare
  task automatic dx(input oag_pkg::oag_mode_t m, input logic [7:0] lo, input logic [7:0] hi,
                    input oag_pkg::oag_kind_t k, input logic [15:0] a);
    dec(m, 3'h0, lo, hi);
    chk({14'h0, r.kind}, {14'h0, k});
    chk(r.addr, a);
  endtask

  // Reset values, read-back, read-only and unmapped places
  task automatic t_regs();
    logic [7:0] ofs[4];
    ofs = '{oag_pkg::OAG_RPS_OFS, oag_pkg::OAG_XPTR_OFS, oag_pkg::OAG_YPTR_OFS,
            oag_pkg::OAG_STAT_OFS};
    foreach (ofs[i]) begin
      rd(ofs[i], d8);
      chk({8'h00, d8}, 16'h0000);
    end
    wr(oag_pkg::OAG_RPS_OFS, 8'ha5);
    wr(oag_pkg::OAG_XPTR_OFS, 8'h3c);
    wr(oag_pkg::OAG_YPTR_OFS, 8'hc3);
    wr(oag_pkg::OAG_STAT_OFS, 8'hff);
    wr(8'h00, 8'h77);
    rd(oag_pkg::OAG_RPS_OFS, d8);
    chk({8'h00, d8}, 16'h00a5);
    rd(oag_pkg::OAG_STAT_OFS, d8);
    chk({8'h00, d8}, 16'h0000);
    rd(8'h00, d8);
    chk({8'h00, d8}, 16'h0000);
    $display("t_regs done");
  endtask

  // Direct families with page a5, X 3c, Y c3
  task automatic t_direct();
    bank(1'b1, 1'b0);
    for (int i = 0; i < 5; i++) begin
      dec(oag_pkg::OAG_M_REG, 3'(i), 8'h11, 8'h22);
      chk({13'h0, r.rsel}, 16'(i));
      chk({14'h0, r.kind}, {14'h0, oag_pkg::OAG_K_REG});
    end
    dec(oag_pkg::OAG_M_IMM, 3'h0, 8'h35, 8'h99);
    chk({8'h00, r.imm}, 16'h0035);
    chk({14'h0, r.kind}, {14'h0, oag_pkg::OAG_K_IMM});
    chk(r.addr, 16'h0000);
    dx(oag_pkg::OAG_M_PG, 8'h35, 8'h99, oag_pkg::OAG_K_DATA, 16'ha535);
    dx(oag_pkg::OAG_M_ABS, 8'h35, 8'h01, oag_pkg::OAG_K_DATA, 16'h0135);
    dx(oag_pkg::OAG_M_XIND, 8'h00, 8'h00, oag_pkg::OAG_K_DATA, 16'ha53c);
    dx(oag_pkg::OAG_M_PGX, 8'hf5, 8'h00, oag_pkg::OAG_K_DATA, 16'ha531);
    dx(oag_pkg::OAG_M_PGY, 8'h40, 8'h00, oag_pkg::OAG_K_DATA, 16'ha503);
    dx(oag_pkg::OAG_M_ABSY, 8'h80, 8'hff, oag_pkg::OAG_K_DATA, 16'h0043);
    $display("t_direct done");
  endtask

  // Post-increment at the top of the byte range
  task automatic t_xinc();
    wr(oag_pkg::OAG_XPTR_OFS, 8'hff);
    dx(oag_pkg::OAG_M_XINC, 8'h00, 8'h00, oag_pkg::OAG_K_DATA, 16'ha5ff);
    dx(oag_pkg::OAG_M_XIND, 8'h00, 8'h00, oag_pkg::OAG_K_DATA, 16'ha500);
    rd(oag_pkg::OAG_STAT_OFS, d8);
    chk({8'h00, d8}, 16'h0001);
    $display("t_xinc done");
  endtask

  // Clear forces page zero; absolute ignores the flag; set wins a tie
  task automatic t_bank();
    bank(1'b0, 1'b1);
    dx(oag_pkg::OAG_M_PG, 8'h35, 8'h00, oag_pkg::OAG_K_DATA, 16'h0035);
    dx(oag_pkg::OAG_M_ABS, 8'h35, 8'h01, oag_pkg::OAG_K_DATA, 16'h0135);
    rd(oag_pkg::OAG_STAT_OFS, d8);
    chk({8'h00, d8}, 16'h0000);
    bank(1'b1, 1'b1);
    rd(oag_pkg::OAG_STAT_OFS, d8);
    chk({8'h00, d8}, 16'h0001);
    $display("t_bank done");
  endtask

  // Pointer fetches, including wrap at page and address-space ends
  task automatic t_ind();
    wr(oag_pkg::OAG_XPTR_OFS, 8'h10);
    wr(oag_pkg::OAG_YPTR_OFS, 8'h10);
    dx(oag_pkg::OAG_M_IND_PG, 8'hff, 8'h00, oag_pkg::OAG_K_JUMP,
       {mbyte(16'ha500), mbyte(16'ha5ff)});
    dx(oag_pkg::OAG_M_IND_PGY, 8'h25, 8'h00, oag_pkg::OAG_K_DATA,
       {mbyte(16'ha526), mbyte(16'ha525)} + 16'h0010);
    dx(oag_pkg::OAG_M_IND_PGX, 8'hf8, 8'h00, oag_pkg::OAG_K_DATA,
       {mbyte(16'ha509), mbyte(16'ha508)});
    dx(oag_pkg::OAG_M_IND_ABS, 8'hff, 8'hff, oag_pkg::OAG_K_JUMP,
       {mbyte(16'h0000), mbyte(16'hffff)});
    $display("t_ind done");
  endtask

  // Unused code gives nothing; a request during a fetch is dropped
  task automatic t_refuse();
    int seen;
    seen = 0;
    for (int c = 0; c < 10; c++) begin
      @(posedge clk);
      if (c == 0) req <= '{1'b1, oag_pkg::oag_mode_t'(4'hd), oag_pkg::OAG_R_ACC, 8'h10, 8'h00};
      if (c == 1) req <= '{1'b1, oag_pkg::OAG_M_IND_PG, oag_pkg::OAG_R_ACC, 8'h10, 8'h00};
      if (c == 2) req <= '{1'b1, oag_pkg::OAG_M_PG, oag_pkg::OAG_R_ACC, 8'h44, 8'h00};
      if (c == 4) req.valid <= 1'b0;
      #1;
      if (res.valid === 1'b1) begin
        seen++;
        r = res;
      end
    end
    chk(16'(seen), 16'h0001);
    chk({14'h0, r.kind}, {14'h0, oag_pkg::OAG_K_JUMP});
    chk(r.addr, {mbyte(16'ha511), mbyte(16'ha510)});
    $display("t_refuse done");
  endtask

  initial begin
    rstn           = 1'b0;
    reg_addr       = 8'h00;
    reg_wdata      = 8'h00;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    set_bank_bit   = 1'b0;
    clear_bank_bit = 1'b0;
    req            = '0;
    mem_rdata      = 8'h00;
    mismatches     = 0;
    total_checks   = 0;
    cyc            = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // Internal reset copy trails by two edges
    repeat (3) @(posedge clk);
    t_regs();
    t_direct();
    t_xinc();
    t_bank();
    t_ind();
    t_refuse();
    results();
  end
endmodule
